/* File: include/comp_sched_pkg.sv */
// Purpose: Shared constants and types for the lane compensation gate
// Assumes: One parallel clock; request and warning come from logic on that clock
// Notes:   Widths are fixed; the scheduler outside owns period and burst timing
//
// Operation
// - While the request is high the core withholds transmit ready from the user.
// - While the warning is high the core neither acknowledges nor starts a user flow message.
// - The core does not acknowledge native flow messages while the warning or the request is high.
// - The schedule is enough to absorb up to 100 ppm of reference clock mismatch.
// - On every cycle with clock enable high, the request high and the channel up the core sends compensation sequences on all lanes.
// - The core ignores requests until channel up, and the scheduler starts right after it.
package comp_sched_pkg;

    localparam int unsigned LANES      = 2;
    localparam int unsigned LANE_BYTES = 2;

    // Scheduler figures, kept for reference by the bench
    localparam int unsigned PERIOD_2B  = 5000;
    localparam int unsigned BURST_2B   = 6;
    localparam int unsigned PERIOD_4B  = 3000;
    localparam int unsigned BURST_4B   = 3;
    localparam int unsigned MIN_BURST  = 2;
    localparam int unsigned MIN_GAP    = 8;

    localparam logic [LANES-1:0] LANES_NONE = '0;
    localparam logic [LANES-1:0] LANES_ALL  = '1;

    // Link state, one-hot
    typedef enum logic [2:0] {
        ST_DOWN = 3'h1,
        ST_RUN  = 3'h2,
        ST_COMP = 3'h4
    } link_state_e;

    // Per-lane symbol selection toward the encoders
    typedef struct packed {
        logic [LANES-1:0] comp_seq;
        logic [LANES-1:0] data_sel;
    } lane_sel_s;

    // Grants toward the user side
    typedef struct packed {
        logic tx_ready;
        logic ufc_ack;
        logic nfc_ack;
    } grant_s;

    localparam lane_sel_s LANE_SEL_RST = '{comp_seq: LANES_NONE, data_sel: LANES_NONE};
    localparam grant_s    GRANT_RST    = '{tx_ready: 1'b0, ufc_ack: 1'b0, nfc_ack: 1'b0};

endpackage

/* File: rtl/comp_gate.sv */
// Purpose: Gates user data and flow messages around compensation bursts
// Assumes: Request and warning are driven by a scheduler on ref_clk_i
// Notes:   Every output is registered, so it answers one clock after its cause
//          Burst timing and warning lead belong to the scheduler, not to this gate
//          Clock enable low holds every flop, outputs included, unless synchronous reset is high
`timescale 1ns/1ps
module comp_gate (
    input  wire logic                                ref_clk_i,
    input  wire logic                                srst_i,
    input  wire logic                                clk_en_i,
    input  wire logic                                channel_up_i,
    input  wire logic                                comp_insert_request_i,
    input  wire logic                                comp_upcoming_warning_i,
    input  wire logic                                tx_valid_i,
    input  wire logic                                user_flow_message_req_i,
    input  wire logic                                native_flow_message_req_i,
    output logic                                     tx_ready_o,
    output logic                                     user_flow_message_ack_o,
    output logic                                     native_flow_message_ack_o,
    output logic [comp_sched_pkg::LANES-1:0]         comp_seq_lanes_o,
    output logic [comp_sched_pkg::LANES-1:0]         data_lanes_o
);

    comp_sched_pkg::link_state_e state_q;
    comp_sched_pkg::link_state_e state_d;
    comp_sched_pkg::lane_sel_s   lane_q;
    comp_sched_pkg::lane_sel_s   lane_d;
    comp_sched_pkg::grant_s      grant_q;
    comp_sched_pkg::grant_s      grant_d;
    logic                        comp_now;

    // Shared grant gate for both flow message kinds
    // Ack flop feedback keeps a held request from being granted twice in a row
    function automatic logic flow_open(
        input logic up,
        input logic req,
        input logic ack_q,
        input logic warn,
        input logic burst
    );
        return up & req & ~ack_q & ~warn & ~burst;
    endfunction

    // Requests count only once the channel is up
    assign comp_now = channel_up_i & comp_insert_request_i;

    // Link state next value
    always_comb begin
        state_d = state_q;
        case (state_q)
            comp_sched_pkg::ST_DOWN: begin
                if (channel_up_i) begin
                    state_d = comp_insert_request_i ? comp_sched_pkg::ST_COMP : comp_sched_pkg::ST_RUN;
                end
            end
            comp_sched_pkg::ST_RUN,
            comp_sched_pkg::ST_COMP: begin
                if (!channel_up_i) begin
                    state_d = comp_sched_pkg::ST_DOWN;
                end else if (comp_now) begin
                    state_d = comp_sched_pkg::ST_COMP;
                end else begin
                    state_d = comp_sched_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = comp_sched_pkg::ST_DOWN;
            end
        endcase
    end

    // Lane selection and grants; no burst cycle with clock enable high is dropped or merged
    always_comb begin
        lane_d  = comp_sched_pkg::LANE_SEL_RST;
        grant_d = comp_sched_pkg::GRANT_RST;
        if (comp_now) begin
            lane_d.comp_seq = comp_sched_pkg::LANES_ALL;
        end else if (channel_up_i && tx_valid_i) begin
            lane_d.data_sel = comp_sched_pkg::LANES_ALL;
        end
        // Ready held low for the whole burst
        grant_d.tx_ready = channel_up_i & ~comp_insert_request_i;
        // One-cycle ack per request; warning or burst blocks it
        grant_d.ufc_ack = flow_open(channel_up_i,
                                    user_flow_message_req_i,
                                    grant_q.ufc_ack,
                                    comp_upcoming_warning_i,
                                    comp_insert_request_i);
        grant_d.nfc_ack = flow_open(channel_up_i,
                                    native_flow_message_req_i,
                                    grant_q.nfc_ack,
                                    comp_upcoming_warning_i,
                                    comp_insert_request_i);
    end

    // Registers; reset wins, otherwise clock enable low freezes everything
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= comp_sched_pkg::ST_DOWN;
            lane_q  <= comp_sched_pkg::LANE_SEL_RST;
            grant_q <= comp_sched_pkg::GRANT_RST;
        end else if (clk_en_i) begin
            state_q <= state_d;
            lane_q  <= lane_d;
            grant_q <= grant_d;
        end
    end

    // Outputs straight from flops
    assign tx_ready_o                = grant_q.tx_ready;
    assign user_flow_message_ack_o   = grant_q.ufc_ack;
    assign native_flow_message_ack_o = grant_q.nfc_ack;
    assign comp_seq_lanes_o          = lane_q.comp_seq;
    assign data_lanes_o              = lane_q.data_sel;

    // Checks on the registered answers
    a_ready_blocked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && comp_insert_request_i |=> !tx_ready_o)
        else $error("ready high after a compensation request");

    a_ufc_warn_block: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && comp_upcoming_warning_i |=> !user_flow_message_ack_o)
        else $error("user flow ack during warning");

    a_nfc_blocked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && (comp_upcoming_warning_i || comp_insert_request_i) |=> !native_flow_message_ack_o)
        else $error("native flow ack during warning or request");

    a_comp_all_lanes: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && channel_up_i && comp_insert_request_i
        |=> comp_seq_lanes_o == comp_sched_pkg::LANES_ALL && data_lanes_o == comp_sched_pkg::LANES_NONE)
        else $error("compensation not sent on all lanes");

    a_down_ignored: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && !channel_up_i |=> comp_seq_lanes_o == comp_sched_pkg::LANES_NONE && !tx_ready_o)
        else $error("request acted on while channel down");

    a_burst_kept: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (clk_en_i && comp_now) [*2] |=> $past(comp_seq_lanes_o) == comp_sched_pkg::LANES_ALL
        && comp_seq_lanes_o == comp_sched_pkg::LANES_ALL)
        else $error("compensation cycle dropped inside a burst");

    a_comp_only_req: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && !comp_insert_request_i |=> comp_seq_lanes_o == comp_sched_pkg::LANES_NONE)
        else $error("compensation sent without request");

    a_ufc_ack_pulse: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && user_flow_message_ack_o |=> !user_flow_message_ack_o)
        else $error("user flow ack longer than one cycle");

    // Flow acks are single pulses and need the channel up
    a_nfc_ack_pulse: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && native_flow_message_ack_o |=> !native_flow_message_ack_o)
        else $error("native flow ack longer than one cycle");

    a_ufc_req_block: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && comp_insert_request_i |=> !user_flow_message_ack_o)
        else $error("user flow ack during compensation burst");

    a_ack_needs_up: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && !channel_up_i |=> !user_flow_message_ack_o && !native_flow_message_ack_o)
        else $error("flow ack while channel down");

    // Ready and data return as soon as a burst ends
    a_ready_open: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && channel_up_i && !comp_insert_request_i |=> tx_ready_o)
        else $error("ready withheld without a request");

    a_data_open: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && channel_up_i && !comp_insert_request_i && tx_valid_i
        |=> data_lanes_o == comp_sched_pkg::LANES_ALL)
        else $error("user data not sent outside a burst");

    a_lanes_exclusive: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (comp_seq_lanes_o & data_lanes_o) == comp_sched_pkg::LANES_NONE)
        else $error("lane carries data and compensation at once");

    // Link state must track the channel and the burst
    a_state_down: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && !channel_up_i |=> state_q == comp_sched_pkg::ST_DOWN)
        else $error("state not down while channel down");

    a_state_comp: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && comp_now |=> state_q == comp_sched_pkg::ST_COMP)
        else $error("state not in burst during request");

    a_state_run: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        clk_en_i && channel_up_i && !comp_insert_request_i |=> state_q == comp_sched_pkg::ST_RUN)
        else $error("state not running between bursts");

    // A frozen clock enable must hold ready and both lane outputs
    a_freeze_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !clk_en_i |=> $stable({tx_ready_o, comp_seq_lanes_o, data_lanes_o}))
        else $error("outputs moved while clock enable low");

    c_down_recover: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        !channel_up_i ##1 channel_up_i ##2 tx_ready_o);

    c_ufc_granted: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        user_flow_message_ack_o);

    c_burst_six: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        (clk_en_i && comp_now) [*6] ##1 !comp_insert_request_i);

    c_warn_then_req: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        comp_upcoming_warning_i && !comp_insert_request_i ##3 comp_now);


endmodule

/* File: dv/comp_sched_model.sv */
// Purpose: Behavioural compensation scheduler facing the gate
// Assumes: Drives its outputs on the falling edge of ref_clk_i
// Notes:   PERIOD is shortened so a run sees several bursts
`timescale 1ns/1ps
module comp_sched_model #(
    parameter int unsigned PERIOD   = 40,
    parameter int unsigned LANE_B   = comp_sched_pkg::LANE_BYTES,
    parameter int unsigned IF_BYTES = comp_sched_pkg::LANES * comp_sched_pkg::LANE_BYTES,
    parameter int unsigned MAX_MSG  = 2,
    // Burst length follows lane width
    parameter int unsigned BURST    = (LANE_B == 4) ? comp_sched_pkg::BURST_4B : comp_sched_pkg::BURST_2B,
    // Lead is 2 plus the words a largest message spans
    parameter int unsigned LEAD     = (MAX_MSG + IF_BYTES - 1) / IF_BYTES + 2
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic channel_up_i,
    input  wire logic enable_i,
    output logic      comp_insert_request_o,
    output logic      comp_upcoming_warning_o
);
    int unsigned cnt_q;
    // Count restarts when down, so the first burst follows channel up closely
    always @(negedge ref_clk_i) begin
        if (srst_i || !channel_up_i || !enable_i) begin
            cnt_q <= 0;
            comp_insert_request_o   <= 1'b0;
            comp_upcoming_warning_o <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            comp_insert_request_o   <= (cnt_q >= LEAD) && (cnt_q < LEAD + BURST);
            comp_upcoming_warning_o <= (cnt_q < LEAD + BURST);
        end
    end
endmodule

/* File: dv/link_clock_comp_scheduling_tb_top.sv */
// Purpose: Self-checking bench for the compensation gate
// Assumes: Inputs change on the falling edge; outputs registered
// Notes:   A cycle model predicts every output from sampled inputs
`timescale 1ns/1ps
module link_clock_comp_scheduling_tb_top;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic channel_up_i = 1'b0;
    logic sched_up = 1'b0;
    logic sched_en = 1'b1;
    logic tx_valid_i = 1'b1;
    logic ufc_req = 1'b0;
    logic nfc_req = 1'b0;
    logic req, warn, tx_ready_o, ufc_ack, nfc_ack;
    logic [comp_sched_pkg::LANES-1:0] comp_lanes, data_lanes;
    comp_sched_pkg::grant_s    exp_g;
    comp_sched_pkg::lane_sel_s exp_l;
    int error_cnt = 0;
    int checks = 0;

    // Free-running 250 MHz clock
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    comp_gate dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i), .channel_up_i(channel_up_i),
        .comp_insert_request_i(req), .comp_upcoming_warning_i(warn), .tx_valid_i(tx_valid_i),
        .user_flow_message_req_i(ufc_req), .native_flow_message_req_i(nfc_req), .tx_ready_o(tx_ready_o),
        .user_flow_message_ack_o(ufc_ack), .native_flow_message_ack_o(nfc_ack),
        .comp_seq_lanes_o(comp_lanes), .data_lanes_o(data_lanes));
    comp_sched_model sched (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .channel_up_i(sched_up),
        .enable_i(sched_en), .comp_insert_request_o(req), .comp_upcoming_warning_o(warn));

    task automatic check(input logic [3:0] seen, input logic [3:0] expd, input string what);
        checks++;
        if (seen !== expd) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, seen, expd);
        end
    endtask

    // Predict at the rising edge, compare once outputs have settled
    task automatic cyc(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            if (srst_i) begin
                exp_g = comp_sched_pkg::GRANT_RST;
                exp_l = comp_sched_pkg::LANE_SEL_RST;
            end else if (clk_en_i) begin
                exp_l.comp_seq = {comp_sched_pkg::LANES{channel_up_i & req}};
                exp_l.data_sel = {comp_sched_pkg::LANES{channel_up_i & ~req & tx_valid_i}};
                exp_g.tx_ready = channel_up_i & ~req;
                exp_g.ufc_ack  = ufc_req & channel_up_i & ~warn & ~req & ~exp_g.ufc_ack;
                exp_g.nfc_ack  = nfc_req & channel_up_i & ~warn & ~req & ~exp_g.nfc_ack;
            end
            @(negedge ref_clk_i);
            check({2'h0, comp_lanes}, {2'h0, exp_l.comp_seq}, "comp lanes");
            check({2'h0, data_lanes}, {2'h0, exp_l.data_sel}, "data lanes");
            check({3'h0, tx_ready_o}, {3'h0, exp_g.tx_ready}, "tx ready");
            check({3'h0, ufc_ack}, {3'h0, exp_g.ufc_ack}, "user ack");
            check({3'h0, nfc_ack}, {3'h0, exp_g.nfc_ack}, "native ack");
        end
    endtask

    task automatic t_link_down();
        sched_up = 1'b1;
        ufc_req = 1'b1;
        nfc_req = 1'b1;
        cyc(50);
        $display("test link down done");
    endtask

    task automatic t_bursts();
        channel_up_i = 1'b1;
        cyc(90);
        ufc_req = 1'b0;
        tx_valid_i = 1'b0;
        cyc(40);
        $display("test bursts done");
    endtask

    task automatic t_freeze();
        clk_en_i = 1'b0;
        cyc(7);
        clk_en_i = 1'b1;
        tx_valid_i = 1'b1;
        cyc(40);
        $display("test freeze done");
    endtask

    task automatic t_shared_ref();
        sched_en = 1'b0;
        ufc_req = 1'b1;
        cyc(50);
        sched_en = 1'b1;
        cyc(5);
        srst_i = 1'b1;
        cyc(2);
        srst_i = 1'b0;
        cyc(40);
        $display("test shared reference done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard shares the single closing path
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end

    initial begin
        cyc(12);
        srst_i = 1'b0;
        t_link_down();
        t_bursts();
        t_freeze();
        t_shared_ref();
        final_report();
    end
endmodule
